// file: slot_start_gate.sv
// Slot counter and slot start mask gating.
`timescale 1ns/10ps
module slot_start_gate #(
    parameter int SLOTS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Slot timing events
    input wire logic sifsElapsed,
    input wire logic slotBoundary,
    // Configuration
    input wire logic [SLOTS-1:0] slotMask,
    input wire logic [1:0] slotWindow,
    // Gating result
    output logic [$clog2(SLOTS)-1:0] slotNumber,
    output logic slotStartEnable
);
    localparam int SW = $clog2(SLOTS);
    logic [SW-1:0] slotNum_q;
    logic [SW-1:0] slotNum_d;
    wire maskActive = slotWindow != 2'h0;

    // Slot 0 is the one that starts as SIFS runs out; idle or busy
    // slots both advance the count, which wraps modulo the mask size.
    assign slotNum_d = sifsElapsed ? '0 :
        slotBoundary ? SW'(slotNum_q + 1'b1) : slotNum_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            slotNum_q <= '0;
        else
            slotNum_q <= slotNum_d;
    end

    // A set mask bit forbids a start, but only with a nonzero window.
    assign slotStartEnable = !maskActive
        || !slotMask[slotNum_q];
    assign slotNumber = slotNum_q;

    a_slot_zero: assert property (@(posedge clk) disable iff (!nrst)
        sifsElapsed |=> slotNum_q == '0)
        else $error("slot count not zero after SIFS");
    a_slot_step: assert property (@(posedge clk) disable iff (!nrst)
        slotBoundary && !sifsElapsed |=>
        slotNum_q == SW'($past(slotNum_q) + 1'b1))
        else $error("slot count did not advance");
    a_window_off: assert property (@(posedge clk) disable iff (!nrst)
        slotWindow == 2'h0 |-> slotStartEnable)
        else $error("mask applied with zero window");
    a_mask_block: assert property (@(posedge clk) disable iff (!nrst)
        maskActive && slotMask[slotNum_q] |-> !slotStartEnable)
        else $error("masked slot allowed a start");
endmodule : slot_start_gate

// file: tx_channel_access_gating_regs.sv
// AXI4-Lite register bank for transmit pause, slot mask and filters.
// What this block does
// - Paused status waits for all requested units.
// - No pause requests means paused reads one.
// - Each request bit asks its unit pause.
// - Slot mask only acts with nonzero window.
// - Slot zero at SIFS end, then increments.
// - Mask bit n blocks slots n mod 16.
// - 128 filter bits per unit, reset cleared.
// - Filter array read through 40 word locations.
// - Host offset maps to six-bit location index.
// - Index 49 sets rows of selected units.
// - Index 48 clears rows of selected units.
// - Index 0 op field: clear or set.
// - Index 0 unit field picks the unit.
// - Index 0 slice field picks 16 bits.
// - Only mask-one bits of the slice change.
// - Index 4D+k reads word k of unit D.
`timescale 1ns/10ps
module tx_channel_access_gating_regs #(
    parameter int UNITS = 10,
    parameter int BITS = 128,
    parameter int SLOTS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Unit pause handshake
    input wire logic [UNITS-1:0] unitTransmitting,
    output logic [UNITS-1:0] unitPauseRequest,
    // Slot timing and gating
    input wire logic sifsElapsed,
    input wire logic slotBoundary,
    output logic [$clog2(SLOTS)-1:0] slotNumber,
    output logic slotStartEnable,
    // Filter bits
    output logic [UNITS*BITS-1:0] filterBits
);
    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------

    // Offset = base + (m[4:0] << 6) + (m[5] << 2), so the low six bits
    // of the offset are 0x38 or 0x3C and bits 10:6 carry m[4:0].
    function automatic logic filtHit(input logic [31:0] a);
        logic [15:0] off;
        off = a[15:0];
        filtHit = a[31:16] == tx_gating_pkg::FILT_PAGE
            && off[15:11] == tx_gating_pkg::FILT_BASE_OFF[15:11]
            && off[5:3] == tx_gating_pkg::FILT_BASE_OFF[5:3]
            && off[1:0] == 2'h0;
    endfunction : filtHit

    function automatic logic [5:0] filtIdx(input logic [31:0] a);
        filtIdx = {a[2], a[10:6]};
    endfunction : filtIdx

    // Byte strobes widened to a bit mask.
    function automatic logic [31:0] laneMask(input logic [3:0] s);
        laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : laneMask

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] s);
        merge = (old & ~laneMask(s)) | (nw & laneMask(s));
    endfunction : merge

    // ------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------
    logic awHeld_q;
    logic wHeld_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [31:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // Address and data are caught independently, in either order.
    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire wrFire = awHeld_q && wHeld_q && !bvalid_q;
    wire bDone = bvalid_q && s_axi_bready;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 32'h0000_0000;
        end
        else if (awTake)
        begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end
        else if (wrFire)
            awHeld_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end
        else if (wTake)
        begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
        else if (wrFire)
            wHeld_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire wrPause = wrFire && awAddr_q == tx_gating_pkg::PAUSE_ADDR;
    wire wrMask = wrFire && awAddr_q == tx_gating_pkg::SLOT_MASK_ADDR;
    wire wrMisc = wrFire && awAddr_q == tx_gating_pkg::MISC_ADDR;
    wire wrFilt = wrFire && filtHit(awAddr_q);
    wire wrKnown = wrPause || wrMask || wrMisc || wrFilt;
    // Unstrobed lanes of a filter command count as zero, which makes
    // them harmless mask bits rather than stale bus data.
    wire [31:0] filtCmdData = wData_q & laneMask(wStrb_q);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= tx_gating_pkg::RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wrKnown ? tx_gating_pkg::RESP_OKAY
                : tx_gating_pkg::RESP_SLVERR;
        end
        else if (bDone)
            bvalid_q <= 1'b0;
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [UNITS-1:0] req_q;
    logic [SLOTS-1:0] mask_q;
    logic [1:0] win_q;
    logic paused_q;
    logic [31:0] reqMerged;
    logic [31:0] maskMerged;
    logic [31:0] miscMerged;

    assign reqMerged = merge(32'(req_q), wData_q, wStrb_q);
    assign maskMerged = merge(32'(mask_q), wData_q, wStrb_q);
    assign miscMerged = merge({5'h00, win_q, 25'h0000000},
        wData_q, wStrb_q);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            req_q <= UNITS'(tx_gating_pkg::REQ_RESET);
            mask_q <= SLOTS'(tx_gating_pkg::MASK_RESET);
            win_q <= tx_gating_pkg::WIN_RESET;
        end
        else
        begin
            if (wrPause)
                req_q <= reqMerged[UNITS-1:0];
            if (wrMask)
                mask_q <= maskMerged[SLOTS-1:0];
            if (wrMisc)
                win_q <= miscMerged[tx_gating_pkg::MISC_WIN_LSB +: 2];
        end
    end

    // Each set request bit holds its unit's pause line high.
    assign unitPauseRequest = req_q;

    // ------------------------------------------------------------------
    // Pause status
    // ------------------------------------------------------------------

    // Paused only once no requested unit is still sending; with no
    // request at all the status is one. It lags the units by a cycle.
    wire stillBusy = |(req_q & unitTransmitting);
    always_ff @(posedge clk)
    begin
        if (!nrst)
            paused_q <= tx_gating_pkg::PAUSED_RESET;
        else
            paused_q <= !stillBusy;
    end

    // ------------------------------------------------------------------
    // Slot gating and filter storage
    // ------------------------------------------------------------------
    logic [31:0] filtRdData;

    slot_start_gate #(
        .SLOTS(SLOTS)
    ) u_gate (
        .clk(clk),
        .nrst(nrst),
        .sifsElapsed(sifsElapsed),
        .slotBoundary(slotBoundary),
        .slotMask(mask_q),
        .slotWindow(win_q),
        .slotNumber(slotNumber),
        .slotStartEnable(slotStartEnable)
    );

    // Writes to other indices are dropped inside the array.
    tx_filter_array #(
        .UNITS(UNITS),
        .BITS(BITS)
    ) u_filter (
        .clk(clk),
        .nrst(nrst),
        .wrEn(wrFilt),
        .wrIdx(filtIdx(awAddr_q)),
        .wrData(filtCmdData),
        .rdIdx(filtIdx(s_axi_araddr)),
        .rdData(filtRdData),
        .filterBits(filterBits)
    );

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rdNext;
    logic rdKnown;

    assign s_axi_arready = !rvalid_q;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire rdPause = s_axi_araddr == tx_gating_pkg::PAUSE_ADDR;
    wire rdMask = s_axi_araddr == tx_gating_pkg::SLOT_MASK_ADDR;
    wire rdMisc = s_axi_araddr == tx_gating_pkg::MISC_ADDR;
    wire rdFilt = filtHit(s_axi_araddr);
    wire [31:0] pauseWord = 32'(req_q)
        | (32'(paused_q) << tx_gating_pkg::PAUSED_BIT);

    // Reads only select a word; no read path touches stored state.
    assign rdKnown = rdPause || rdMask || rdMisc || rdFilt;
    assign rdNext = rdFilt ? filtRdData :
        rdPause ? pauseWord :
        rdMask ? 32'(mask_q) :
        rdMisc ? (32'(win_q) << tx_gating_pkg::MISC_WIN_LSB) :
        32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tx_gating_pkg::RESP_OKAY;
        end
        else if (arTake)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rdNext;
            rresp_q <= rdKnown ? tx_gating_pkg::RESP_OKAY
                : tx_gating_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_busy_unit;
        stillBusy;
    endsequence
    sequence s_read_take;
        arTake ##1 rvalid_q;
    endsequence

    a_paused_idle: assert property (@(posedge clk) disable iff (!nrst)
        req_q == '0 |=> paused_q)
        else $error("paused low with no requests");
    a_paused_busy: assert property (@(posedge clk) disable iff (!nrst)
        s_busy_unit |=> !paused_q)
        else $error("paused high while unit sending");
    a_pause_write: assert property (@(posedge clk) disable iff (!nrst)
        wrPause && wStrb_q[1:0] == 2'h3 |=>
        unitPauseRequest == $past(wData_q[UNITS-1:0]))
        else $error("pause request not taken");
    a_read_data: assert property (@(posedge clk) disable iff (!nrst)
        arTake && rdFilt |=> s_axi_rdata == $past(filtRdData))
        else $error("filter read word wrong");
    a_read_still: assert property (@(posedge clk) disable iff (!nrst)
        s_read_take and (!wrFilt [*2]) |-> $stable(filterBits))
        else $error("read changed filter bits");
    // Status recovers once quiet, and empty filter words read zero.
    a_pause_done: assert property (@(posedge clk) disable iff (!nrst)
        !stillBusy |=> paused_q)
        else $error("paused low with all units stopped");
    a_empty_word: assert property (@(posedge clk) disable iff (!nrst)
        arTake && rdFilt && filtIdx(s_axi_araddr) >=
        tx_gating_pkg::FILT_READ_END |=> s_axi_rdata == 32'h0000_0000)
        else $error("empty filter word not zero");
endmodule : tx_channel_access_gating_regs

// file: tx_channel_access_gating_regs_bench.sv
// Self-checking bench for the transmit access gating register bank.
`timescale 1ns/10ps
module tx_channel_access_gating_regs_bench;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [9:0] unitTransmitting = 10'h000;
    logic [9:0] unitPauseRequest;
    logic sifsElapsed = 1'b0, slotBoundary = 1'b0, slotStartEnable;
    logic [3:0] slotNumber;
    logic [1279:0] filterBits;
    logic [127:0] expF [10];
    int failures = 0;
    int numChecks = 0;

    // Full byte lanes always; strobe merging is not the subject here.
    tx_channel_access_gating_regs i_dut (.clk(clk), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .unitTransmitting(unitTransmitting),
        .unitPauseRequest(unitPauseRequest), .sifsElapsed(sifsElapsed),
        .slotBoundary(slotBoundary), .slotNumber(slotNumber),
        .slotStartEnable(slotStartEnable), .filterBits(filterBits));

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ------------------------------------------------------------------
    // Bus master; handshakes are judged at the falling edge so the value
    // seen is the one the next rising edge samples.
    // ------------------------------------------------------------------
    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic awHs, wHs, bHs, done;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        r = 2'h3;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge clk);
            awHs = s_axi_awvalid & s_axi_awready;
            wHs = s_axi_wvalid & s_axi_wready;
            bHs = s_axi_bvalid & s_axi_bready;
            if (bHs) r = s_axi_bresp;
            @(posedge clk);
            if (awHs) s_axi_awvalid <= 1'b0;
            if (wHs) s_axi_wvalid <= 1'b0;
            if (bHs) s_axi_bready <= 1'b0;
            done = bHs;
        end
        if (!done)
        begin
            failures++;
            end_sim();
        end
    endtask : axiWrite

    task automatic axiRead(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic arHs, rHs, done;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge clk);
            arHs = s_axi_arvalid & s_axi_arready;
            rHs = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (arHs) s_axi_arvalid <= 1'b0;
            if (rHs) s_axi_rready <= 1'b0;
            done = rHs;
        end
        if (!done)
        begin
            failures++;
            end_sim();
        end
    endtask : axiRead

    task automatic wrOk(input logic [31:0] a, input logic [31:0] d);
        axiWrite(a, d, resp);
        chk(resp, 2'h0);
    endtask : wrOk

    task automatic rdChk(input logic [31:0] a, input logic [31:0] e,
        input logic [1:0] er);
        axiRead(a, rd, resp);
        chk(rd, e);
        chk(resp, er);
    endtask : rdChk

    // Byte address of filter location m, worked out independently.
    function automatic logic [31:0] fa(input int m);
        fa = 32'h1000_1038 + 32'((m & 'h1F) << 6) + 32'((m & 'h20) >> 3);
    endfunction : fa

    // Reads every location, then compares the unit outputs as well.
    task automatic checkFilters();
        for (int m = 0; m < 64; m++)
            rdChk(fa(m), (m < 40) ? expF[m / 4][32 * (m % 4) +: 32] : 0,
                2'h0);
        for (int u = 0; u < 10; u++)
            chk(filterBits[u * 128 +: 128], expF[u]);
    endtask : checkFilters

    task automatic doReset();
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (expF[u]) expF[u] = '0;
    endtask : doReset

    task automatic pulse(input logic sifs);
        @(posedge clk);
        if (sifs) sifsElapsed <= 1'b1;
        else slotBoundary <= 1'b1;
        @(posedge clk);
        sifsElapsed <= 1'b0;
        slotBoundary <= 1'b0;
        @(negedge clk);
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testReset();
        rdChk(32'h1000_1270, 32'h0001_0000, 2'h0);
        rdChk(32'h1000_12F0, 32'h0, 2'h0);
        rdChk(32'h1000_1000, 32'h0, 2'h2);
        axiWrite(32'h1000_1004, 32'hFFFF_FFFF, resp);
        chk(resp, 2'h2);
        checkFilters();
        $display("test reset done");
    endtask : testReset

    task automatic testPause();
        unitTransmitting <= 10'h004;
        wrOk(32'h1000_1270, 32'hFFFF_FC05);
        chk(unitPauseRequest, 10'h005);
        rdChk(32'h1000_1270, 32'h0000_0005, 2'h0);
        unitTransmitting <= 10'h3FA;
        rdChk(32'h1000_1270, 32'h0001_0005, 2'h0);
        unitTransmitting <= 10'h3FF;
        wrOk(32'h1000_1270, 32'h0);
        chk(unitPauseRequest, 10'h000);
        rdChk(32'h1000_1270, 32'h0001_0000, 2'h0);
        $display("test pause done");
    endtask : testPause

    task automatic testSlot();
        logic [15:0] mk;
        logic [31:0] md;
        mk = 16'h8002;
        wrOk(32'h1000_12F0, {16'hFFFF, mk});
        rdChk(32'h1000_12F0, {16'h0, mk}, 2'h0);
        for (int w = 0; w < 2; w++)
        begin
            md = (w == 0) ? 32'hF9FF_FFFF : 32'h0600_0000;
            wrOk(32'h1000_10F0, md);
            rdChk(32'h1000_10F0, md & 32'h0600_0000, 2'h0);
            pulse(1'b1);
            for (int n = 0; n < 17; n++)
            begin
                chk(slotNumber, n % 16);
                chk(slotStartEnable, (w == 0) || !mk[n % 16]);
                pulse(1'b0);
            end
        end
        $display("test slot done");
    endtask : testSlot

    task automatic testFilter();
        wrOk(fa(49), 32'hFFFF_FE05);
        expF[0] = '1;
        expF[2] = '1;
        expF[9] = '1;
        checkFilters();
        wrOk(fa(48), 32'h0000_0204);
        wrOk(fa(49), 32'h0000_0002);
        wrOk(fa(0), 32'h0013_0404);
        wrOk(fa(0), 32'h0197_8001);
        expF[1] = '1;
        expF[1][50] = 1'b0;
        expF[1][58] = 1'b0;
        expF[2] = '0;
        expF[9] = {1'b1, 14'h0, 1'b1, 112'h0};
        // Reserved command, slice and unit values must leave bits alone.
        wrOk(fa(0), 32'h0290_FFFF);
        wrOk(fa(0), 32'h0198_FFFF);
        wrOk(fa(0), 32'h01A0_FFFF);
        for (int s = 0; s < 8; s++)
        begin
            wrOk(fa(0), 32'h0150_0000 | (s << 16) | (1 << s));
            expF[5][16 * s + s] = 1'b1;
        end
        checkFilters();
        doReset();
        checkFilters();
        $display("test filter done");
    endtask : testFilter

    // Main sequence.
    initial
    begin
        doReset();
        testReset();
        testPause();
        testSlot();
        testFilter();
        end_sim();
    end
endmodule : tx_channel_access_gating_regs_bench

// file: tx_filter_array.sv
// Transmit filter bit storage with set, clear and slice commands.
`timescale 1ns/10ps
module tx_filter_array #(
    parameter int UNITS = 10,
    parameter int BITS = 128
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Command port
    input wire logic wrEn,
    input wire logic [5:0] wrIdx,
    input wire logic [31:0] wrData,
    // Read port
    input wire logic [5:0] rdIdx,
    output logic [31:0] rdData,
    // Filter bits to the units
    output logic [UNITS*BITS-1:0] filterBits
);
    tx_gating_pkg::filter_cmd_s cmd;
    logic [BITS-1:0] rows [UNITS];
    assign cmd = wrData;

    // Reserved ops, slices and unit numbers make the command a no-op.
    wire cmdOk = wrEn && wrIdx == tx_gating_pkg::FILT_CMD_IDX
        && (cmd.op == tx_gating_pkg::OP_CLEAR
        || cmd.op == tx_gating_pkg::OP_SET)
        && 32'(cmd.unit) < UNITS
        && cmd.slice < tx_gating_pkg::SLICE_COUNT;
    wire setAll = wrEn && wrIdx == tx_gating_pkg::FILT_SET_IDX;
    wire clrAll = wrEn && wrIdx == tx_gating_pkg::FILT_CLR_IDX;
    wire [BITS-1:0] sliceMask = BITS'(cmd.mask) << {cmd.slice, 4'h0};

    genvar u;
    generate
        for (u = 0; u < UNITS; u++)
        begin : g_unit
            logic [BITS-1:0] row_q;
            logic [BITS-1:0] row_d;
            wire hit = cmdOk && 32'(cmd.unit) == u;
            // Whole-row commands land in one edge, so no unit ever
            // sees a half-updated row.
            assign row_d = (setAll && wrData[u]) ? '1 :
                (clrAll && wrData[u]) ? '0 :
                !hit ? row_q :
                (cmd.op == tx_gating_pkg::OP_SET) ?
                (row_q | sliceMask) : (row_q & ~sliceMask);
            always_ff @(posedge clk)
            begin
                if (!nrst)
                    row_q <= '0;
                else
                    row_q <= row_d;
            end
            assign rows[u] = row_q;
            assign filterBits[u*BITS +: BITS] = row_q;

            a_set_all: assert property (@(posedge clk)
                disable iff (!nrst)
                setAll && wrData[u] |=> row_q == '1)
                else $error("set-all did not fill row");
            a_clear_all: assert property (@(posedge clk)
                disable iff (!nrst)
                clrAll && wrData[u] && !(setAll) |=> row_q == '0)
                else $error("clear-all did not empty row");
            a_cmd_keep: assert property (@(posedge clk)
                disable iff (!nrst)
                hit |=> (row_q & ~$past(sliceMask))
                == ($past(row_q) & ~$past(sliceMask)))
                else $error("unmasked filter bit changed");
            a_cmd_set: assert property (@(posedge clk)
                disable iff (!nrst)
                hit && cmd.op == tx_gating_pkg::OP_SET |=>
                (row_q & $past(sliceMask)) == $past(sliceMask))
                else $error("slice set missed bits");
        end
    endgenerate

    // Four words per unit; indices past the last unit read as zero.
    wire rdOk = rdIdx < tx_gating_pkg::FILT_READ_END
        && 32'(rdIdx[5:2]) < UNITS;
    assign rdData = rdOk ?
        rows[rdIdx[5:2]][{rdIdx[1:0], 5'h00} +: 32] : 32'h0000_0000;
endmodule : tx_filter_array

// file: tx_gating_pkg.sv
// Shared constants and types for the transmit access gating registers.
package tx_gating_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] PAUSE_ADDR = 32'h1000_1270;
    localparam logic [31:0] SLOT_MASK_ADDR = 32'h1000_12F0;
    localparam logic [31:0] MISC_ADDR = 32'h1000_10F0;
    localparam logic [15:0] FILT_PAGE = 16'h1000;
    localparam logic [15:0] FILT_BASE_OFF = 16'h1038;
    // ------------------------------------------------------------------
    // Filter location indices and commands
    // ------------------------------------------------------------------
    localparam logic [5:0] FILT_CMD_IDX = 6'h00;
    localparam logic [5:0] FILT_CLR_IDX = 6'h30;
    localparam logic [5:0] FILT_SET_IDX = 6'h31;
    localparam logic [5:0] FILT_READ_END = 6'h28;
    localparam logic [3:0] OP_CLEAR = 4'h0;
    localparam logic [3:0] OP_SET = 4'h1;
    localparam logic [3:0] SLICE_COUNT = 4'h8;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int PAUSED_BIT = 16;
    localparam int MISC_WIN_LSB = 25;
    localparam logic PAUSED_RESET = 1'h1;
    localparam logic [9:0] REQ_RESET = 10'h000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [1:0] WIN_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Write data layout of the filter command location.
    typedef struct packed {
        logic [3:0] rsvd;
        logic [3:0] op;
        logic [3:0] unit;
        logic [3:0] slice;
        logic [15:0] mask;
    } filter_cmd_s;
endpackage : tx_gating_pkg
